// ===== design/panel_mode_pkg.sv
// Panel mode decode constants: register offsets, field positions, resets.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package panel_mode_pkg;

  // Register byte addresses
  localparam logic [7:0] PANEL_CFG_OFF = 8'h00;
  localparam logic [7:0] MODE_CFG_OFF = 8'h04;
  localparam logic [7:0] PWR_CFG_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  // Panel configuration fields
  localparam int WIDTH_LSB = 0;
  localparam int COLOR_BIT = 5;
  localparam int DUAL_BIT = 6;
  localparam int ACTIVE_BIT = 7;
  // Mode configuration fields
  localparam int HIPERF_BIT = 0;
  localparam int BPP_LSB = 6;
  // Power field
  localparam int PWR_LSB = 0;

  localparam logic [7:0] PANEL_CFG_RST = 8'h00;
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [1:0] PWR_RST = 2'h0;

  localparam logic [1:0] PWR_SAVE1 = 2'h0;
  localparam logic [1:0] PWR_NORMAL = 2'h3;

  // Memory clock divisors per depth; high performance uses the last
  localparam logic [3:0] MEM_DIV_1BPP = 4'h8;
  localparam logic [3:0] MEM_DIV_2BPP = 4'h4;
  localparam logic [3:0] MEM_DIV_4BPP = 4'h2;
  localparam logic [3:0] MEM_DIV_SAME = 4'h1;

  typedef enum logic [3:0] {
    FMT_RESERVED = 4'h0,
    FMT_MONO_S4 = 4'h1,
    FMT_MONO_S8 = 4'h2,
    FMT_MONO_D8 = 4'h3,
    FMT_COL_S4 = 4'h4,
    FMT_COL_S8F1 = 4'h5,
    FMT_COL_S8F2 = 4'h6,
    FMT_COL_D8 = 4'h7,
    FMT_ACT9 = 4'h8,
    FMT_ACT12 = 4'h9
  } panel_fmt_t;

  typedef struct packed {
    logic [3:0] bpp;       // 1, 2, 4 or 8 bits per pixel; 0 reserved
    logic [3:0] memDiv;    // Memory clock = pixel clock / memDiv
    logic bppValid;
  } depth_t;

endpackage : panel_mode_pkg

// ===== design/mem_clk_divider.sv
// Memory clock enable divider: one-cycle pulse every div pixel clocks.
// Assumes the pixel rate is the module clock itself.
`timescale 1ns/1ps
module mem_clk_divider
  import panel_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [3:0] div,
  // Enable out
  output logic memEn
);

  logic [3:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      memEn <= 1'b0;
    end else if (!run) begin
      cnt_r <= 4'h0;
      memEn <= 1'b0;
    end else if (cnt_r + 4'h1 >= div) begin
      cnt_r <= 4'h0;
      memEn <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      memEn <= 1'b0;
    end
  end

endmodule : mem_clk_divider

// ===== design/panel_mode_decode.sv
// Panel output mode decode with APB configuration registers.
// Assumes an APB master on clk; the panel takes the decoded mode levels.
`timescale 1ns/1ps
module panel_mode_decode
  import panel_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel side
  output panel_fmt_t panelFmt,
  output logic [3:0] dataWidth,
  output logic fmtReserved,
  output logic normalMode,
  output logic pwrSave,
  output logic [3:0] bitsPerPixel,
  output logic memClkEn
);

  logic [7:0] panelCfg_r;
  logic [7:0] modeCfg_r;
  logic [1:0] pwr_r;
  panel_fmt_t fmt_nxt;
  logic [3:0] width_nxt;
  depth_t depth_nxt;
  logic wrEn;
  logic mapped;
  logic memEnRaw;
  logic [31:0] statusWord;

  // Write lands on the access edge, so a setup alone changes nothing
  assign wrEn = psel && penable && pwrite;
  assign mapped = (paddr == PANEL_CFG_OFF) || (paddr == MODE_CFG_OFF) ||
                  (paddr == PWR_CFG_OFF) || (paddr == STATUS_OFF);
  // Status reads the registered outputs, so it matches the format, width, reserved and depth pins
  assign statusWord = {16'h0000, 3'h0, fmtReserved, bitsPerPixel, dataWidth,
                       panelFmt};

  // Configuration registers, one per concern
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      panelCfg_r <= PANEL_CFG_RST;
    end else if (wrEn && paddr == PANEL_CFG_OFF) begin
      panelCfg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeCfg_r <= MODE_CFG_RST;
    end else if (wrEn && paddr == MODE_CFG_OFF) begin
      modeCfg_r <= pwdata[7:0];
    end
  end

  // Upper power bits are dropped; reserved codes are stored as written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= PWR_RST;
    end else if (wrEn && paddr == PWR_CFG_OFF) begin
      pwr_r <= pwdata[PWR_LSB +: 2];
    end
  end

  // Panel format decode
  always_comb begin
    logic [1:0] w;
    w = panelCfg_r[WIDTH_LSB +: 2];
    fmt_nxt = FMT_RESERVED;
    width_nxt = 4'h0;
    if (panelCfg_r[ACTIVE_BIT]) begin
      // Dual bit ignored for active panels
      fmt_nxt = w[0] ? FMT_ACT12 : FMT_ACT9;
      width_nxt = w[0] ? 4'hC : 4'h9;
    end else begin
      case ({panelCfg_r[COLOR_BIT], panelCfg_r[DUAL_BIT], w})
        4'b0000: fmt_nxt = FMT_MONO_S4;
        4'b0001: fmt_nxt = FMT_MONO_S8;
        4'b0101: fmt_nxt = FMT_MONO_D8;
        4'b1000: fmt_nxt = FMT_COL_S4;
        4'b1001: fmt_nxt = FMT_COL_S8F1;
        4'b1011: fmt_nxt = FMT_COL_S8F2;
        4'b1101: fmt_nxt = FMT_COL_D8;
        default: fmt_nxt = FMT_RESERVED;
      endcase
      // Reserved codes leave the width at zero
      if (fmt_nxt != FMT_RESERVED) begin
        width_nxt = (w == 2'b00) ? 4'h4 : 4'h8;
      end
    end
  end

  // Depth and memory clock ratio
  always_comb begin
    depth_nxt.bppValid = 1'b1;
    case (modeCfg_r[BPP_LSB +: 2])
      2'b00: begin
        depth_nxt.bpp = 4'h1;
        depth_nxt.memDiv = MEM_DIV_1BPP;
      end
      2'b01: begin
        depth_nxt.bpp = 4'h2;
        depth_nxt.memDiv = MEM_DIV_2BPP;
      end
      2'b10: begin
        depth_nxt.bpp = 4'h4;
        depth_nxt.memDiv = MEM_DIV_4BPP;
      end
      default: begin
        depth_nxt.bpp = 4'h8;
        depth_nxt.memDiv = MEM_DIV_SAME;
        // 8 bpp gray shade is reserved
        depth_nxt.bppValid = panelCfg_r[COLOR_BIT];
      end
    endcase
    // High performance trades power for a full-rate memory clock
    if (modeCfg_r[HIPERF_BIT]) begin
      depth_nxt.memDiv = MEM_DIV_SAME;
    end
  end

  // Registered format outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      panelFmt <= FMT_MONO_S4;
      dataWidth <= 4'h4;
      fmtReserved <= 1'b0;
    end else begin
      panelFmt <= fmt_nxt;
      dataWidth <= width_nxt;
      fmtReserved <= (fmt_nxt == FMT_RESERVED) || !depth_nxt.bppValid;
    end
  end

  // Reserved power codes keep the panel in power save
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      normalMode <= 1'b0;
      pwrSave <= 1'b1;
    end else begin
      normalMode <= (pwr_r == PWR_NORMAL);
      pwrSave <= (pwr_r != PWR_NORMAL);
    end
  end

  // Reserved depth reads as zero so software sees the refusal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitsPerPixel <= 4'h1;
    end else begin
      bitsPerPixel <= depth_nxt.bppValid ? depth_nxt.bpp : 4'h0;
    end
  end

  // Memory clock stops in power save
  // A ratio change takes hold on the next clock, against the running count
  mem_clk_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(pwr_r == PWR_NORMAL),
    .div(depth_nxt.memDiv),
    .memEn(memEnRaw)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memClkEn <= 1'b0;
    end else begin
      // One cycle later than the divider, but straight off a flop
      memClkEn <= memEnRaw;
    end
  end

  // APB handshake: zero wait states, answer in the access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      // Unmapped offsets are refused, not aliased onto a register
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Read data launched on the setup edge, standing through the access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        PANEL_CFG_OFF: prdata <= {24'h00_0000, panelCfg_r};
        MODE_CFG_OFF: prdata <= {24'h00_0000, modeCfg_r};
        PWR_CFG_OFF: prdata <= {30'h0000_0000, pwr_r};
        STATUS_OFF: prdata <= statusWord;
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : panel_mode_decode

// ===== verif/panel_sink.sv
// Panel stand-in: measures memory clock enable spacing.
// Assumes memClkEn is a one-cycle pulse on clk.
`timescale 1ns/1ps
module panel_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // From controller
  input wire logic memClkEn,
  // Cycles between pulses
  output logic [7:0] gap
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h01;
      gap <= 8'h00;
    end else begin
      cnt_r <= memClkEn ? 8'h01 : cnt_r + 8'h01;
      if (memClkEn) gap <= cnt_r;
    end
  end
endmodule : panel_sink

// ===== verif/panel_mode_decode_assertions.sv
// Checker on the panel mode decode ports.
// Assumes it is bound into panel_mode_decode.
`timescale 1ns/1ps
module panel_mode_decode_assertions
  import panel_mode_pkg::*;
(
  // Clock, reset, APB
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel side
  input wire panel_fmt_t panelFmt,
  input wire logic [3:0] dataWidth,
  input wire logic fmtReserved,
  input wire logic normalMode,
  input wire logic pwrSave,
  input wire logic [3:0] bitsPerPixel,
  input wire logic memClkEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s; psel && !penable; endsequence
  sequence bad_rd_s; setup_s ##0 !pwrite && paddr > 8'h0C; endsequence
  apb_answer_a: assert property (setup_s |=> pready && penable)
    else $error("no answer after setup");
  unmapped_rd_a: assert property (bad_rd_s |=> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  small_width_a: assert property (panelFmt inside {FMT_MONO_S4,
    FMT_COL_S4} |-> dataWidth == 4'h4) else $error("width not 4");
  wide_width_a: assert property (panelFmt inside {FMT_MONO_S8,
    FMT_MONO_D8, FMT_COL_S8F1, FMT_COL_S8F2, FMT_COL_D8}
    |-> dataWidth == 4'h8) else $error("width not 8");
  active_width_a: assert property (panelFmt == FMT_ACT9
    |-> dataWidth == 4'h9) else $error("width not 9");
  active_wide_a: assert property (panelFmt == FMT_ACT12
    |-> dataWidth == 4'hC) else $error("width not 12");
  fmt_reserved_a: assert property (panelFmt == FMT_RESERVED
    |-> fmtReserved && dataWidth == 0) else $error("reserved not flagged");
  power_pair_a: assert property (pwrSave == !normalMode)
    else $error("power flags disagree");
  clock_stop_a: assert property (!normalMode [*3] |-> !memClkEn)
    else $error("memory clock in power save");
  gray_depth_a: assert property (bitsPerPixel inside {0, 1, 2, 4, 8}
    && (bitsPerPixel != 0 || fmtReserved)) else $error("bad depth");
endmodule : panel_mode_decode_assertions

bind panel_mode_decode panel_mode_decode_assertions chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .panelFmt(panelFmt), .dataWidth(dataWidth),
  .fmtReserved(fmtReserved), .normalMode(normalMode), .pwrSave(pwrSave),
  .bitsPerPixel(bitsPerPixel), .memClkEn(memClkEn)
);

// ===== verif/lcd_panel_mode_decode_tb_top.sv
// Top bench: APB stimulus, random noise and corner settings.
// Assumes a zero-wait APB slave and the panel sink model.
`timescale 1ns/1ps
`define CK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module lcd_panel_mode_decode_tb_top
  import panel_mode_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, fmtReserved, normalMode;
  logic pwrSave, memClkEn, rdErr;
  logic [7:0] paddr = 8'h00, c, gap;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r, expWord;
  logic [3:0] dataWidth, bitsPerPixel, e;
  panel_fmt_t panelFmt;
  int compares = 0, miscompares = 0, cyc = 0, seed = 10;
  initial forever #20 clk = ~clk;
  panel_mode_decode DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panelFmt(panelFmt), .dataWidth(dataWidth), .fmtReserved(fmtReserved),
    .normalMode(normalMode), .pwrSave(pwrSave),
    .bitsPerPixel(bitsPerPixel), .memClkEn(memClkEn));
  panel_sink sink (.clk(clk), .rst_n(rst_n), .memClkEn(memClkEn), .gap(gap));
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  function automatic panel_fmt_t efmt(logic [7:0] v);
    if (v[7]) return v[0] ? FMT_ACT12 : FMT_ACT9;
    case ({v[5], v[6], v[1:0]})
      4'h0: return FMT_MONO_S4;
      4'h1: return FMT_MONO_S8;
      4'h5: return FMT_MONO_D8;
      4'h8: return FMT_COL_S4;
      4'h9: return FMT_COL_S8F1;
      4'hB: return FMT_COL_S8F2;
      4'hD: return FMT_COL_D8;
      default: return FMT_RESERVED;
    endcase
  endfunction : efmt
  function automatic logic [3:0] ewid(panel_fmt_t f);
    case (f)
      FMT_RESERVED: return 4'h0;
      FMT_MONO_S4, FMT_COL_S4: return 4'h4;
      FMT_ACT9: return 4'h9;
      FMT_ACT12: return 4'hC;
      default: return 4'h8;
    endcase
  endfunction : ewid
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    `CK("fmt", FMT_MONO_S4, panelFmt)
    for (int p = 0; p < 4; p++) begin
      apb(1'h1, PWR_CFG_OFF, {30'h0000_0000, p[1:0]});
      repeat (2) @(posedge clk);
      `CK("normal", p == 3, normalMode)
      `CK("save", p != 3, pwrSave)
    end
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      c = {i[4:2], 3'h0, i[1:0]};
      apb(1'h1, PANEL_CFG_OFF, {r[31:8], c});
      repeat (2) @(posedge clk);
      `CK("fmt", efmt(c), panelFmt)
      `CK("width", ewid(efmt(c)), dataWidth)
      `CK("fmt resv", efmt(c) == FMT_RESERVED, fmtReserved)
      apb(1'h0, PANEL_CFG_OFF, 32'h0000_0000);
      expWord = {24'h00_0000, c};
      `CK("panel rd", expWord, rd)
      `CK("panel err", 1'h0, rdErr)
    end
    for (int j = 0; j < 8; j++) begin
      r = $random(seed);
      apb(1'h1, PANEL_CFG_OFF, {26'h000_0000, j[2], 5'h01});
      apb(1'h1, MODE_CFG_OFF, {24'h00_0000, j[1:0], 5'h00, r[0]});
      repeat (30) @(posedge clk);
      e = j[2:0] == 3'h3 ? 4'h0 : 4'h1 << j[1:0];
      `CK("bpp", e, bitsPerPixel)
      `CK("resv", e == 0, fmtReserved)
      if (e != 0) `CK("gap", r[0] ? 8'h01 : 8'h08 >> j[1:0], gap)
      apb(1'h0, STATUS_OFF, 32'h0000_0000);
      expWord = {16'h0000, 3'h0, e == 4'h0, e, 4'h8,
                 j[2] ? FMT_COL_S8F1 : FMT_MONO_S8};
      `CK("status", expWord, rd)
    end
    `CK("mem on", 1'h1, memClkEn)
    apb(1'h1, PWR_CFG_OFF, {30'h0000_0000, PWR_SAVE1});
    repeat (4) @(posedge clk);
    `CK("mem off", 1'h0, memClkEn)
    `CK("save", 1'h1, pwrSave)
    apb(1'h0, 8'h40, 32'h0000_0000);
    `CK("unmapped", 32'h0000_0000, rd)
    `CK("unmapped err", 1'h1, rdErr)
    stop_test;
  end
endmodule : lcd_panel_mode_decode_tb_top
